// >>> logic/asbm_regs.svh
`ifndef ASBM_REGS_SVH
`define ASBM_REGS_SVH
// APB byte offsets
`define ASBM_OFF_OPT_STORE 12'h000
`define ASBM_OFF_OPT_ACTIVE 12'h004
`define ASBM_OFF_PAGE_PTR 12'h008
`define ASBM_OFF_BANK 12'h00c
`define ASBM_OFF_MAP 12'h010
// Program memory landmarks
`define ASBM_RESET_ENTRY 16'h0100
`define ASBM_VECTOR_TOP 16'h00ff
`define ASBM_OPT_FIRST 16'h003c
`define ASBM_OPT_LAST 16'h003f
`define ASBM_OPT_ISP 16'h003e
`define ASBM_OPT_SYS 16'h003f
`define ASBM_ENTRY_0 16'h0200
`define ASBM_ENTRY_1 16'h0300
`define ASBM_ENTRY_2 16'h0500
`define ASBM_ENTRY_3 16'h0900
`define ASBM_PROT_0 16'h01ff
`define ASBM_PROT_1 16'h02ff
`define ASBM_PROT_2 16'h04ff
`define ASBM_PROT_3 16'h08ff
// Option byte fields and erased value
`define ASBM_OPT_ERASED 8'hff
`define ASBM_BIT_RELOC_N 7
`define ASBM_BIT_ENTRY_HI 6
`define ASBM_BIT_ENTRY_LO 5
`define ASBM_BIT_PROT_N 2
`define ASBM_BIT_SIZE_HI 1
`define ASBM_BIT_SIZE_LO 0
// Register file landmarks
`define ASBM_UPPER_BASE 8'hc0
`define ASBM_BANK_BASE 8'he0
`define ASBM_PAGE_PTR_ADDR 8'hdf
`define ASBM_PP_RESET 8'h00
`define ASBM_LCD_PAGE 4'h3
`define ASBM_LCD_LAST 8'h15
`define ASBM_PAGE_LAST 4'h4
`endif

// >>> logic/asbm_pkg.sv
package asbm_pkg;
    // Register addressing mode of a CPU access
    typedef enum logic [1:0] {
        ASBM_MODE_DIRECT,
        ASBM_MODE_WORKING,
        ASBM_MODE_INDIRECT,
        ASBM_MODE_INDEXED
    } asbm_mode_type;
    // Decoded register region
    typedef enum logic [2:0] {
        ASBM_REG_PRIME,
        ASBM_REG_COMMON,
        ASBM_REG_LOWER_BANK,
        ASBM_REG_UPPER_BANK,
        ASBM_REG_SECOND_UPPER_SET
    } asbm_region_type;
    // Register bus request from the CPU
    typedef struct packed {
        logic valid;
        logic write;
        asbm_mode_type mode;
        logic [7:0] addr;
        logic [7:0] wdata;
    } asbm_rf_req_type;
    // Decoded register select toward the register file
    typedef struct packed {
        logic valid;
        logic write;
        asbm_region_type region;
        logic [3:0] page;
        logic [7:0] offset;
        logic lcd;
    } asbm_rf_sel_type;
    // Program memory erase or program request
    typedef struct packed {
        logic valid;
        logic tool;
        logic [15:0] addr;
        logic [7:0] wdata;
    } asbm_flash_req_type;
endpackage

// >>> logic/asbm_map.sv
`include "asbm_regs.svh"

module asbm_map (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire asbm_pkg::asbm_rf_req_type rf_req,
    input wire logic select_lower_bank_op,
    input wire logic select_upper_bank_op,
    output asbm_pkg::asbm_rf_sel_type rf_sel,
    input wire asbm_pkg::asbm_flash_req_type flash_req,
    output logic flash_grant,
    output logic flash_blocked,
    output logic [15:0] fetch_start,
    output logic isp_enable
);
    import asbm_pkg::*;

    // Stored option bytes and the configuration in force
    logic [7:0] opt_isp_q, opt_sys_q;
    logic [7:0] act_isp_q, act_sys_q;
    logic [7:0] register_page_pointer_q; // Destination high, source low
    logic bank_upper_q; // Set when upper bank addressed
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    asbm_rf_sel_type rf_sel_q;
    logic flash_grant_q, flash_blocked_q;
    logic [15:0] fetch_start_q;
    logic isp_enable_q;

    // Option decode of the configuration in force
    wire reloc_on = ~act_isp_q[`ASBM_BIT_RELOC_N];
    wire prot_on = ~act_isp_q[`ASBM_BIT_PROT_N];
    wire [1:0] entry_sel = {act_isp_q[`ASBM_BIT_ENTRY_HI], act_isp_q[`ASBM_BIT_ENTRY_LO]};
    wire [1:0] size_sel = {act_isp_q[`ASBM_BIT_SIZE_HI], act_isp_q[`ASBM_BIT_SIZE_LO]};
    // Relocated entry choice, bits ignored when relocation off
    wire [15:0] reloc_entry = (entry_sel == 2'h0) ? `ASBM_ENTRY_0 :
                              (entry_sel == 2'h1) ? `ASBM_ENTRY_1 :
                              (entry_sel == 2'h2) ? `ASBM_ENTRY_2 : `ASBM_ENTRY_3;
    wire [15:0] start_d = reloc_on ? reloc_entry : `ASBM_RESET_ENTRY;
    // Protected area top, area begins at the normal entry
    wire [15:0] prot_top = (size_sel == 2'h0) ? `ASBM_PROT_0 :
                           (size_sel == 2'h1) ? `ASBM_PROT_1 :
                           (size_sel == 2'h2) ? `ASBM_PROT_2 : `ASBM_PROT_3;
    // Vector area is not protected, only the programming area
    wire in_prot = (flash_req.addr >= `ASBM_RESET_ENTRY) && (flash_req.addr <= prot_top);
    wire blocked_d = flash_req.valid && !flash_req.tool && prot_on && in_prot;
    // Option area hit on the 16-bit program bus
    wire opt_hit = (flash_req.addr >= `ASBM_OPT_FIRST) && (flash_req.addr <= `ASBM_OPT_LAST);
    wire opt_isp_hit = flash_req.valid && (flash_req.addr == `ASBM_OPT_ISP);
    wire opt_sys_hit = flash_req.valid && (flash_req.addr == `ASBM_OPT_SYS);
    wire tool_isp = opt_isp_hit && flash_req.tool;
    wire tool_sys = opt_sys_hit && flash_req.tool;
    wire sw_isp = opt_isp_hit && !blocked_d;
    wire sw_sys = opt_sys_hit && !blocked_d;

    // Register bus decode
    wire upper = rf_req.addr >= `ASBM_UPPER_BASE;
    wire banked = rf_req.addr >= `ASBM_BANK_BASE;
    wire via_pointer = (rf_req.mode == ASBM_MODE_INDIRECT) || (rf_req.mode == ASBM_MODE_INDEXED);
    // Destination nibble for writes, source nibble for reads
    wire [3:0] page_d = rf_req.write ? register_page_pointer_q[7:4] : register_page_pointer_q[3:0];
    wire asbm_region_type region_d = !upper ? ASBM_REG_PRIME :
                                     via_pointer ? ASBM_REG_SECOND_UPPER_SET :
                                     !banked ? ASBM_REG_COMMON :
                                     bank_upper_q ? ASBM_REG_UPPER_BANK : ASBM_REG_LOWER_BANK;
    // First set ignores the page, prime and second set follow it
    wire first_upper_set = upper && !via_pointer;
    wire [3:0] sel_page = first_upper_set ? 4'h0 : page_d;
    wire lcd_d = !upper && (page_d == `ASBM_LCD_PAGE) && (rf_req.addr <= `ASBM_LCD_LAST);
    // Page pointer reached only by direct register addressing
    wire pp_cpu_wr = rf_req.valid && rf_req.write && (rf_req.mode == ASBM_MODE_DIRECT)
                     && (rf_req.addr == `ASBM_PAGE_PTR_ADDR);

    // APB decode
    wire apb_acc = psel && penable && !pready_q;
    wire hit_store = paddr == `ASBM_OFF_OPT_STORE;
    wire hit_active = paddr == `ASBM_OFF_OPT_ACTIVE;
    wire hit_pp = paddr == `ASBM_OFF_PAGE_PTR;
    wire hit_bank = paddr == `ASBM_OFF_BANK;
    wire hit_map = paddr == `ASBM_OFF_MAP;
    wire apb_map = hit_store | hit_active | hit_pp | hit_bank | hit_map;
    wire pp_apb_wr = apb_acc && pwrite && hit_pp;
    wire bank_apb_wr = apb_acc && pwrite && hit_bank;
    wire [31:0] rd_mux = hit_store ? {16'h0000, opt_sys_q, opt_isp_q} :
                         hit_active ? {16'h0000, act_sys_q, act_isp_q} :
                         hit_pp ? {24'h000000, register_page_pointer_q} :
                         hit_bank ? {31'h00000000, bank_upper_q} :
                         hit_map ? {15'h0000, isp_enable_q, fetch_start_q} : 32'h00000000;

    // Stored option bytes, written by software or tool
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_isp_q <= `ASBM_OPT_ERASED;
            opt_sys_q <= `ASBM_OPT_ERASED;
        end else if (ce) begin
            if (sw_isp) begin
                opt_isp_q <= flash_req.wdata;
            end
            if (sw_sys) begin
                opt_sys_q <= flash_req.wdata;
            end
        end
    end

    // Options in force, only the programming tool applies them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_isp_q <= `ASBM_OPT_ERASED;
            act_sys_q <= `ASBM_OPT_ERASED;
        end else if (ce) begin
            if (tool_isp) begin
                act_isp_q <= flash_req.wdata;
            end
            if (tool_sys) begin
                act_sys_q <= flash_req.wdata;
            end
        end
    end

    // Page pointer, CPU write takes priority over APB
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            register_page_pointer_q <= `ASBM_PP_RESET;
        end else if (ce) begin
            if (pp_cpu_wr) begin
                register_page_pointer_q <= rf_req.wdata;
            end else if (pp_apb_wr) begin
                register_page_pointer_q <= pwdata[7:0];
            end
        end
    end

    // Bank select, lower bank op wins on a tie
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_upper_q <= 1'b0;
        end else if (ce) begin
            if (select_lower_bank_op) begin
                bank_upper_q <= 1'b0;
            end else if (select_upper_bank_op) begin
                bank_upper_q <= 1'b1;
            end else if (bank_apb_wr) begin
                bank_upper_q <= pwdata[0];
            end
        end
    end

    // APB answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (ce) begin
            pready_q <= apb_acc;
            pslverr_q <= apb_acc && !apb_map;
            prdata_q <= (apb_acc && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // Register select toward the register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rf_sel_q <= '0;
        end else if (ce) begin
            rf_sel_q.valid <= rf_req.valid;
            rf_sel_q.write <= rf_req.write;
            rf_sel_q.region <= region_d;
            rf_sel_q.page <= sel_page;
            rf_sel_q.offset <= rf_req.addr;
            rf_sel_q.lcd <= lcd_d;
        end
    end

    // Flash request verdict, vector area never blocked, protected area blocked for software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_grant_q <= 1'b0;
            flash_blocked_q <= 1'b0;
        end else if (ce) begin
            flash_grant_q <= flash_req.valid && !blocked_d;
            flash_blocked_q <= blocked_d;
        end
    end

    // Fetch start and programming area enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_start_q <= `ASBM_RESET_ENTRY;
            isp_enable_q <= 1'b0;
        end else if (ce) begin
            fetch_start_q <= start_d;
            isp_enable_q <= reloc_on;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign rf_sel = rf_sel_q;
    assign flash_grant = flash_grant_q;
    assign flash_blocked = flash_blocked_q;
    assign fetch_start = fetch_start_q;
    assign isp_enable = isp_enable_q;

    // Fetch start follows relocation enable
    property p_start_default;
        @(posedge pclk) disable iff (!presetn)
        ce && act_isp_q[`ASBM_BIT_RELOC_N] |=> fetch_start_q == `ASBM_RESET_ENTRY;
    endproperty
    a_start_default: assert property (p_start_default) else $error("start not 0100h");

    property p_start_reloc;
        @(posedge pclk) disable iff (!presetn)
        ce && !act_isp_q[`ASBM_BIT_RELOC_N] && entry_sel == 2'h3
        |=> fetch_start_q == `ASBM_ENTRY_3 && isp_enable_q;
    endproperty
    a_start_reloc: assert property (p_start_reloc) else $error("relocated entry wrong");

    // Software write to option byte 3Eh leaves the active 3Eh byte
    property p_sw_no_apply;
        @(posedge pclk) disable iff (!presetn)
        ce && opt_isp_hit && !flash_req.tool |=> $stable(act_isp_q);
    endproperty
    a_sw_no_apply: assert property (p_sw_no_apply) else $error("active options moved");

    property p_protect;
        @(posedge pclk) disable iff (!presetn)
        ce && flash_req.valid && !flash_req.tool && !act_isp_q[`ASBM_BIT_PROT_N]
        && flash_req.addr == `ASBM_RESET_ENTRY |=> flash_blocked_q && !flash_grant_q;
    endproperty
    a_protect: assert property (p_protect) else $error("protected write allowed");

    property p_vector_open;
        @(posedge pclk) disable iff (!presetn)
        ce && flash_req.valid && flash_req.addr <= `ASBM_VECTOR_TOP |=> flash_grant_q;
    endproperty
    a_vector_open: assert property (p_vector_open) else $error("vector area refused");

    property p_second_upper_set;
        @(posedge pclk) disable iff (!presetn)
        ce && rf_req.valid && upper && via_pointer |=> rf_sel_q.region == ASBM_REG_SECOND_UPPER_SET;
    endproperty
    a_second_upper_set: assert property (p_second_upper_set) else $error("second set not selected");

    property p_first_upper_set_page;
        @(posedge pclk) disable iff (!presetn)
        ce && rf_req.valid && upper && rf_req.mode == ASBM_MODE_DIRECT
        |=> rf_sel_q.region != ASBM_REG_SECOND_UPPER_SET && rf_sel_q.page == 4'h0;
    endproperty
    a_first_upper_set_page: assert property (p_first_upper_set_page) else $error("first set paged");

    property p_bank_op;
        @(posedge pclk) disable iff (!presetn)
        ce && select_upper_bank_op && !select_lower_bank_op ##1 ce && rf_req.valid
        && banked && rf_req.mode == ASBM_MODE_DIRECT |=> rf_sel_q.region == ASBM_REG_UPPER_BANK;
    endproperty
    a_bank_op: assert property (p_bank_op) else $error("upper bank not used");

    property p_reset_state;
        @(posedge pclk)
        !presetn |-> register_page_pointer_q == `ASBM_PP_RESET && !bank_upper_q;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

    // Software writes anywhere in the option area leave both active bytes
    property p_opt_area;
        @(posedge pclk) disable iff (!presetn)
        ce && flash_req.valid && !flash_req.tool && opt_hit
        |=> $stable(act_isp_q) && $stable(act_sys_q);
    endproperty
    a_opt_area: assert property (p_opt_area) else $error("option area applied");

    // Display area flagged on page 3 reads
    property p_lcd;
        @(posedge pclk) disable iff (!presetn)
        ce && rf_req.valid && !upper && !rf_req.write
        && register_page_pointer_q[3:0] == `ASBM_LCD_PAGE && rf_req.addr <= `ASBM_LCD_LAST
        |=> rf_sel_q.lcd;
    endproperty
    a_lcd: assert property (p_lcd) else $error("display area missed");

endmodule // asbm_map

// >>> tb/asbm_cpu_model.sv
// CPU core stand-in: register bus, bank ops and program-memory writes
module asbm_cpu_model (
    input wire logic pclk,
    output asbm_pkg::asbm_rf_req_type rf_req,
    output logic select_lower_bank_op,
    output logic select_upper_bank_op,
    output asbm_pkg::asbm_flash_req_type flash_req,
    input wire logic flash_grant,
    input wire logic flash_blocked
);
    timeunit 1ns;
    timeprecision 1ns;
    import asbm_pkg::*;

    // Idle bus at time zero
    initial begin
        rf_req = '0;
        flash_req = '0;
        select_lower_bank_op = 1'b0;
        select_upper_bank_op = 1'b0;
    end

    // One register access; idle fields except mode show inverted values
    task automatic reg_acc(input logic w, input asbm_mode_type m, input logic [7:0] a,
            input logic [7:0] d);
        @(posedge pclk);
        rf_req <= '{valid: 1'b1, write: w, mode: m, addr: a, wdata: d};
        @(posedge pclk);
        rf_req <= '{valid: 1'b0, write: ~w, mode: m, addr: ~a, wdata: ~d};
        #1;
    endtask

    // One-cycle bank select pulse
    task automatic bank_op(input logic up);
        @(posedge pclk);
        select_upper_bank_op <= up;
        select_lower_bank_op <= ~up;
        @(posedge pclk);
        select_upper_bank_op <= 1'b0;
        select_lower_bank_op <= 1'b0;
    endtask

    // Program or erase request; returns {grant, blocked}
    task automatic flash(input logic tool, input logic [15:0] a, input logic [7:0] d,
            output logic [1:0] res);
        @(posedge pclk);
        flash_req <= '{valid: 1'b1, tool: tool, addr: a, wdata: d};
        @(posedge pclk);
        flash_req <= '{valid: 1'b0, tool: ~tool, addr: ~a, wdata: ~d};
        #1;
        res = {flash_grant, flash_blocked};
    endtask

    // Tool writes option byte 3Eh; protection size equals area choice
    task automatic tool_area_opt(input logic reloc_n, input logic [1:0] sel,
            input logic prot_n, output logic [1:0] res);
        flash(1'b1, 16'h003e, {reloc_n, sel, 2'b11, prot_n, sel}, res);
    endtask
endmodule // asbm_cpu_model

// >>> tb/test_address_space_boot_option_map.sv
`include "asbm_regs.svh"

module test_address_space_boot_option_map;
    timeunit 1ns;
    timeprecision 1ns;
    import asbm_pkg::*;
    logic pclk = 1'b0; // 100 ns clock
    logic presetn; // Reset, active low, driven low at time zero
    logic ce = 1'b1; // Clock enable
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    asbm_rf_req_type rf_req; // From the CPU model
    logic lower_op;
    logic upper_op;
    asbm_rf_sel_type rf_sel;
    asbm_flash_req_type flash_req;
    logic flash_grant;
    logic flash_blocked;
    logic [15:0] fetch_start;
    logic isp_enable;
    int n_fail = 0; // Mismatch count
    int comparisons = 0; // Check count
    logic [31:0] rd; // Last read data
    logic err; // Last error flag
    logic [1:0] res; // Last program result
    logic [15:0] entry [4] = '{16'h0200, 16'h0300, 16'h0500, 16'h0900};

    asbm_map dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rf_req(rf_req),
        .select_lower_bank_op(lower_op), .select_upper_bank_op(upper_op),
        .rf_sel(rf_sel), .flash_req(flash_req), .flash_grant(flash_grant),
        .flash_blocked(flash_blocked), .fetch_start(fetch_start), .isp_enable(isp_enable));

    asbm_cpu_model cpu (.pclk(pclk), .rf_req(rf_req), .select_lower_bank_op(lower_op),
        .select_upper_bank_op(upper_op), .flash_req(flash_req),
        .flash_grant(flash_grant), .flash_blocked(flash_blocked));

    // Clock generator
    always #50 pclk = ~pclk;

    // Verdict and end of run
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t ns: %s", $time, m);
        end
    endtask

    // APB transfer; holds request until pready seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Register read with expected value
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string m);
        apb(1'b0, a, 32'h00000000);
        check(rd, exp, m);
    endtask

    // Register bus access and decoded select check
    task automatic rfchk(input logic w, input asbm_mode_type md, input logic [7:0] a,
            input logic [7:0] d, input asbm_region_type r, input logic [3:0] pg,
            input logic l);
        cpu.reg_acc(w, md, a, d);
        check({14'h0, rf_sel}, {14'h0, 1'b1, w, r, pg, a, l}, "register select");
    endtask

    // Reset checks after power-up and after a mid-run reset
    task automatic reset_state();
        rdchk(`ASBM_OFF_MAP, 32'h00000100, "reset entry");
        rdchk(`ASBM_OFF_PAGE_PTR, 32'h00000000, "page pointer");
        rdchk(`ASBM_OFF_BANK, 32'h00000000, "bank");
        rdchk(`ASBM_OFF_OPT_ACTIVE, 32'h0000ffff, "active options");
    endtask

    // Main sequence
    initial begin
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        reset_state();
        rfchk(1'b0, ASBM_MODE_DIRECT, 8'h05, 8'h00, ASBM_REG_PRIME, 4'h0, 1'b0);
        rfchk(1'b1, ASBM_MODE_DIRECT, 8'hdf, 8'h31, ASBM_REG_COMMON, 4'h0, 1'b0);
        rdchk(`ASBM_OFF_PAGE_PTR, 32'h00000031, "pointer load");
        rfchk(1'b0, ASBM_MODE_INDIRECT, 8'hc5, 8'h00, ASBM_REG_SECOND_UPPER_SET, 4'h1, 1'b0);
        rfchk(1'b1, ASBM_MODE_INDEXED, 8'hc5, 8'h00, ASBM_REG_SECOND_UPPER_SET, 4'h3, 1'b0);
        rfchk(1'b0, ASBM_MODE_DIRECT, 8'hc5, 8'h00, ASBM_REG_COMMON, 4'h0, 1'b0);
        rfchk(1'b0, ASBM_MODE_WORKING, 8'hf0, 8'h00, ASBM_REG_LOWER_BANK, 4'h0, 1'b0);
        // Access in the cycle right after the bank op
        fork
            cpu.bank_op(1'b1);
            begin
                @(posedge pclk);
                rfchk(1'b0, ASBM_MODE_DIRECT, 8'hf0, 8'h00, ASBM_REG_UPPER_BANK, 4'h0,
                    1'b0);
            end
        join
        rdchk(`ASBM_OFF_BANK, 32'h00000001, "bank op");
        cpu.bank_op(1'b0);
        rfchk(1'b0, ASBM_MODE_DIRECT, 8'he0, 8'h00, ASBM_REG_LOWER_BANK, 4'h0, 1'b0);
        // Bank op while the clock enable is low is ignored
        @(posedge pclk);
        ce <= 1'b0;
        cpu.bank_op(1'b1);
        ce <= 1'b1;
        rdchk(`ASBM_OFF_BANK, 32'h00000000, "frozen bank op");
        apb(1'b1, `ASBM_OFF_PAGE_PTR, 32'h00000033);
        rfchk(1'b0, ASBM_MODE_DIRECT, 8'h15, 8'h00, ASBM_REG_PRIME, 4'h3, 1'b1);
        rfchk(1'b0, ASBM_MODE_DIRECT, 8'h16, 8'h00, ASBM_REG_PRIME, 4'h3, 1'b0);
        apb(1'b0, 12'h020, 32'h00000000);
        check({31'h0, err}, 32'h00000001, "unmapped error");
        check(rd, 32'h00000000, "unmapped read");
        apb(1'b1, `ASBM_OFF_MAP, 32'h00000000);
        rdchk(`ASBM_OFF_MAP, 32'h00000100, "read-only map");
        cpu.flash(1'b0, 16'h003e, 8'h00, res);
        check({30'h0, res}, 32'h00000002, "software option write");
        rdchk(`ASBM_OFF_OPT_STORE, 32'h0000ff00, "stored options");
        rdchk(`ASBM_OFF_OPT_ACTIVE, 32'h0000ffff, "active unchanged");
        rdchk(`ASBM_OFF_MAP, 32'h00000100, "entry unchanged");
        for (int s = 0; s < 4; s++) begin
            cpu.tool_area_opt(1'b0, s[1:0], 1'b0, res);
            check({30'h0, res}, 32'h00000002, "tool option write");
            rdchk(`ASBM_OFF_MAP, {15'h0, 1'b1, entry[s]}, "relocated entry");
            check({16'h0, fetch_start}, {16'h0, entry[s]}, "fetch start");
            check({31'h0, isp_enable}, 32'h00000001, "area enable");
            cpu.flash(1'b0, 16'h0100, 8'h00, res);
            check({30'h0, res}, 32'h00000001, "area bottom");
            cpu.flash(1'b0, entry[s] - 16'h0001, 8'h00, res);
            check({30'h0, res}, 32'h00000001, "area top");
            cpu.flash(1'b0, entry[s], 8'h00, res);
            check({30'h0, res}, 32'h00000002, "above area");
        end
        cpu.flash(1'b0, 16'h00ff, 8'h00, res);
        check({30'h0, res}, 32'h00000002, "vector area");
        cpu.tool_area_opt(1'b1, 2'b10, 1'b1, res);
        rdchk(`ASBM_OFF_MAP, 32'h00000100, "relocation off");
        check({31'h0, isp_enable}, 32'h00000000, "area disabled");
        cpu.flash(1'b0, 16'h0100, 8'h00, res);
        check({30'h0, res}, 32'h00000002, "protection off");
        cpu.flash(1'b1, 16'h003f, 8'h5a, res);
        cpu.flash(1'b1, 16'h003c, 8'h00, res);
        rdchk(`ASBM_OFF_OPT_ACTIVE, 32'h00005ade, "option bytes");
        rdchk(`ASBM_OFF_OPT_STORE, 32'h00005ade, "stored follows tool");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        reset_state();
        stop_test();
    end

    // Hang guard
    initial begin
        #1000000;
        n_fail++;
        stop_test();
    end
endmodule // test_address_space_boot_option_map
